// *** common/crrsx_defines.svh ***
// Constants for the return/rotate/subtract/xor execution slice.
// Assumes inclusion by bare name from package and rtl files.
`ifndef CRRSX_DEFINES_SVH
`define CRRSX_DEFINES_SVH
`define CRRSX_PC_W       10
`define CRRSX_STK_DEPTH  5
`define CRRSX_PTR_W      3
`define CRRSX_WDOG_W     8
`define CRRSX_PRE_W      8
`define CRRSX_RET_CYCLES 2'h2
`define CRRSX_W_RST      8'h00
`endif

// *** common/crrsx_pkg.sv ***
// Types for the execution slice.
// Assumes crrsx_defines.svh is on the include path.
`include "crrsx_defines.svh"
package crrsx_pkg;
  // Operation select codes
  typedef enum logic [3:0] {
    OP_NONE        = 4'h0,
    OP_POP_LIT     = 4'h1,
    OP_RETURN      = 4'h2,
    OP_ROT_LEFT    = 4'h3,
    OP_ROT_RIGHT   = 4'h4,
    OP_SLEEP       = 4'h5,
    OP_SUB_BORROW  = 4'h6,
    OP_REG_MINUS_W = 4'h7,
    OP_LIT_MINUS_W = 4'h8,
    OP_NIBBLE_EXCH = 4'h9,
    OP_REG_XOR     = 4'ha,
    OP_LIT_XOR     = 4'hb,
    OP_CALL        = 4'hc
  } crrsx_op_type;
  // Sequencer state
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_RET2  = 2'b01,
    ST_SLEEP = 2'b10
  } crrsx_state_type;
endpackage

// *** rtl/crrsx_alu.sv ***
// Combinational result and flag unit.
// Assumes operands are stable for the whole cycle of the operation.
`timescale 1ns/1ps
`default_nettype none
module crrsx_alu
  import crrsx_pkg::*;
(
  // Operation and operands
  input  wire crrsx_op_type op,
  input  wire logic [7:0]   fileVal,
  input  wire logic [7:0]   workVal,
  input  wire logic [7:0]   literal,
  input  wire logic         carryIn,
  // Result and flags
  output logic [7:0]        result,
  output logic              carryOut,
  output logic              halfOut,
  output logic              zeroOut,
  output logic              setsArith,
  output logic              setsCarry,
  output logic              setsZero
);
  logic [8:0] sum;
  logic [4:0] lowSum;

  // Adder shared by all subtracts; minus W is plus ~W plus one
  always_comb begin
    sum = 9'h000;
    lowSum = 5'h00;
    result = fileVal;
    carryOut = carryIn;
    halfOut = 1'b0;
    setsArith = 1'b0;
    setsCarry = 1'b0;
    setsZero = 1'b0;
    case (op)
      OP_ROT_LEFT: begin
        result = {fileVal[6:0], carryIn};
        carryOut = fileVal[7];
        setsCarry = 1'b1;
      end
      OP_ROT_RIGHT: begin
        result = {carryIn, fileVal[7:1]};
        carryOut = fileVal[0];
        setsCarry = 1'b1;
      end
      OP_SUB_BORROW, OP_REG_MINUS_W, OP_LIT_MINUS_W: begin
        // Borrow-style carry: carry set means no borrow
        sum = {1'b0, (op == OP_LIT_MINUS_W) ? literal : fileVal} + {1'b0, ~workVal}
            + ((op == OP_SUB_BORROW) ? {8'h00, carryIn} : 9'h001);
        lowSum = {1'b0, ((op == OP_LIT_MINUS_W) ? literal[3:0] : fileVal[3:0])}
               + {1'b0, ~workVal[3:0]}
               + ((op == OP_SUB_BORROW) ? {4'h0, carryIn} : 5'h01);
        result = sum[7:0];
        carryOut = sum[8];
        halfOut = lowSum[4];
        setsArith = 1'b1;
        setsZero = 1'b1;
      end
      OP_NIBBLE_EXCH: result = {fileVal[3:0], fileVal[7:4]};
      OP_REG_XOR: begin
        result = workVal ^ fileVal;
        setsZero = 1'b1;
      end
      OP_LIT_XOR: begin
        result = workVal ^ literal;
        setsZero = 1'b1;
      end
      default: result = fileVal;
    endcase
    zeroOut = (result == 8'h00);
  end
endmodule
`default_nettype wire

// *** rtl/crrsx_core.sv ***
// Execution slice: working register, flags, stack, PC, watchdog clear, sleep.
// Assumes one-cycle op strobes from a decoder; a new op is offered only while opReady.
`timescale 1ns/1ps
`default_nettype none
`include "crrsx_defines.svh"
module crrsx_core
  import crrsx_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rstn,
  // Operation request
  input  wire logic                    opValid,
  input  wire crrsx_op_type            opCode,
  input  wire logic                    destBit,
  input  wire logic [7:0]              literal,
  input  wire logic [`CRRSX_PC_W-1:0]  callTarget,
  input  wire logic [7:0]              fileRdata,
  // Wake request from outside the clock domain
  input  wire logic                    wakeReq,
  // File register write-back
  output logic                         fileWe,
  output logic [7:0]                   fileWdata,
  // State
  output logic                         opReady,
  output logic [7:0]                   workingRegister,
  output logic                         carryFlag,
  output logic                         halfCarryFlag,
  output logic                         zeroFlag,
  output logic                         watchdogExpiryFlag,
  output logic                         powerdownFlag,
  output logic [`CRRSX_WDOG_W-1:0]     watchdogCounter,
  output logic [`CRRSX_PRE_W-1:0]      watchdogPrescaler,
  output logic                         sleeping,
  output logic [`CRRSX_PC_W-1:0]       progCounter
);
  logic [7:0]  result;
  logic        cOut;
  logic        hOut;
  logic        zOut;
  logic        setsArith;
  logic        setsCarry;
  logic        setsZero;
  logic        wakeMeta_r;
  logic        wakeSync_r;
  logic        take;
  logic [`CRRSX_PC_W-1:0]  stack_r [`CRRSX_STK_DEPTH];
  logic [`CRRSX_PTR_W-1:0] sp_r;
  logic [`CRRSX_PC_W-1:0]  popAddr_r;
  crrsx_state_type state_r;

  crrsx_alu u_alu (
    .op       (opCode),
    .fileVal  (fileRdata),
    .workVal  (workingRegister),
    .literal  (literal),
    .carryIn  (carryFlag),
    .result   (result),
    .carryOut (cOut),
    .halfOut  (hOut),
    .zeroOut  (zOut),
    .setsArith(setsArith),
    .setsCarry(setsCarry),
    .setsZero (setsZero)
  );

  // Ops are accepted only in the run state
  assign take = opValid && (state_r == ST_RUN);

  // Destination-bit ops: 0 picks working register, 1 the file register
  function automatic logic toFile(input crrsx_op_type op, input logic d);
    toFile = d && (op == OP_ROT_LEFT || op == OP_ROT_RIGHT || op == OP_SUB_BORROW
                   || op == OP_REG_MINUS_W || op == OP_NIBBLE_EXCH || op == OP_REG_XOR);
  endfunction

  // Wake pin synchroniser, second stage is the only reader of the first
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wakeMeta_r <= 1'b0;
      wakeSync_r <= 1'b0;
    end else begin
      wakeMeta_r <= wakeReq;
      wakeSync_r <= wakeMeta_r;
    end
  end

  // Sequencer: returns take a second cycle, sleep waits for a wake
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_RUN;
      opReady <= 1'b1;
      sleeping <= 1'b0;
    end else begin
      case (state_r)
        ST_RUN: begin
          if (take && (opCode == OP_RETURN || opCode == OP_POP_LIT || opCode == OP_CALL)) begin
            state_r <= ST_RET2;
            opReady <= 1'b0;
          end else if (take && opCode == OP_SLEEP) begin
            state_r <= ST_SLEEP;
            opReady <= 1'b0;
            sleeping <= 1'b1;
          end
        end
        ST_RET2: begin
          state_r <= ST_RUN;
          opReady <= 1'b1;
        end
        ST_SLEEP: begin
          if (wakeSync_r) begin
            state_r <= ST_RUN;
            opReady <= 1'b1;
            sleeping <= 1'b0;
          end
        end
        default: begin
          state_r <= ST_RUN;
          opReady <= 1'b1;
          sleeping <= 1'b0;
        end
      endcase
    end
  end

  // Hardware stack and program counter; a full stack wraps onto the oldest slot
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sp_r <= '0;
      progCounter <= '0;
      popAddr_r <= '0;
      for (int i = 0; i < `CRRSX_STK_DEPTH; i++) stack_r[i] <= '0;
    end else if (state_r == ST_RET2) begin
      progCounter <= popAddr_r;
    end else if (take) begin
      case (opCode)
        OP_CALL: begin
          stack_r[sp_r] <= progCounter + `CRRSX_PC_W'(1);
          sp_r <= (sp_r == `CRRSX_PTR_W'(`CRRSX_STK_DEPTH - 1)) ? '0 : sp_r + 3'h1;
          popAddr_r <= callTarget;
        end
        OP_RETURN, OP_POP_LIT: begin
          popAddr_r <= stack_r[(sp_r == '0) ? `CRRSX_PTR_W'(`CRRSX_STK_DEPTH - 1) : sp_r - 3'h1];
          sp_r <= (sp_r == '0) ? `CRRSX_PTR_W'(`CRRSX_STK_DEPTH - 1) : sp_r - 3'h1;
        end
        OP_SLEEP: progCounter <= progCounter + `CRRSX_PC_W'(1);
        default: progCounter <= progCounter + `CRRSX_PC_W'(1);
      endcase
    end
  end

  // Working register and file write-back
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      workingRegister <= `CRRSX_W_RST;
      fileWe <= 1'b0;
      fileWdata <= 8'h00;
    end else begin
      fileWe <= take && toFile(opCode, destBit);
      fileWdata <= result;
      if (take && opCode == OP_POP_LIT)
        workingRegister <= literal;
      else if (take && (opCode == OP_LIT_MINUS_W || opCode == OP_LIT_XOR))
        workingRegister <= result;
      else if (take && !destBit && (setsCarry || setsArith || setsZero
                                    || opCode == OP_NIBBLE_EXCH))
        workingRegister <= result;
    end
  end

  // Arithmetic flags; returns and swap leave them alone
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      carryFlag <= 1'b0;
      halfCarryFlag <= 1'b0;
      zeroFlag <= 1'b0;
    end else if (take) begin
      if (setsCarry || setsArith) carryFlag <= cOut;
      if (setsArith) halfCarryFlag <= hOut;
      if (setsZero) zeroFlag <= zOut;
    end
  end

  // Sleep: expiry set, powerdown cleared, watchdog and prescaler zeroed
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      watchdogExpiryFlag <= 1'b1;
      powerdownFlag <= 1'b1;
      watchdogCounter <= '0;
      watchdogPrescaler <= '0;
    end else if (take && opCode == OP_SLEEP) begin
      watchdogExpiryFlag <= 1'b1;
      powerdownFlag <= 1'b0;
      watchdogCounter <= '0;
      watchdogPrescaler <= '0;
    end else if (!sleeping) begin
      // Free-running watchdog stand-in; stopped while asleep
      {watchdogCounter, watchdogPrescaler} <= {watchdogCounter, watchdogPrescaler} + 16'h0001;
    end
  end

  // Assertions
  sequence s_retStart;
    take && (opCode == OP_RETURN || opCode == OP_POP_LIT);
  endsequence
  property p_retTwo;
    @(posedge clk) disable iff (!rstn) s_retStart |=> !opReady ##1 opReady;
  endproperty
  a_retTwo: assert property (p_retTwo) else $error("return not two cycles");
  property p_popLit;
    @(posedge clk) disable iff (!rstn)
      take && opCode == OP_POP_LIT |=> workingRegister == $past(literal);
  endproperty
  a_popLit: assert property (p_popLit) else $error("literal not loaded");
  property p_retFlags;
    @(posedge clk) disable iff (!rstn) s_retStart |=> $stable(carryFlag) && $stable(zeroFlag);
  endproperty
  a_retFlags: assert property (p_retFlags) else $error("return changed flags");
  property p_sleep;
    @(posedge clk) disable iff (!rstn) take && opCode == OP_SLEEP |=>
      watchdogExpiryFlag && !powerdownFlag && watchdogCounter == 8'h00 && sleeping;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep effects wrong");
  property p_rotLeft;
    @(posedge clk) disable iff (!rstn) take && opCode == OP_ROT_LEFT && !destBit |=>
      workingRegister == {$past(fileRdata[6:0]), $past(carryFlag)}
      && carryFlag == $past(fileRdata[7]);
  endproperty
  a_rotLeft: assert property (p_rotLeft) else $error("rotate left wrong");
  property p_dest;
    @(posedge clk) disable iff (!rstn) take && opCode == OP_REG_XOR |=> fileWe == $past(destBit);
  endproperty
  a_dest: assert property (p_dest) else $error("destination wrong");
  property p_swap;
    @(posedge clk) disable iff (!rstn) take && opCode == OP_NIBBLE_EXCH |=>
      $stable(carryFlag) && $stable(zeroFlag)
      && fileWdata == {$past(fileRdata[3:0]), $past(fileRdata[7:4])};
  endproperty
  a_swap: assert property (p_swap) else $error("swap wrong");
  property p_litSub;
    @(posedge clk) disable iff (!rstn) take && opCode == OP_LIT_MINUS_W |=>
      workingRegister == 8'($past(literal) - $past(workingRegister))
      && zeroFlag == (workingRegister == 8'h00);
  endproperty
  a_litSub: assert property (p_litSub) else $error("literal subtract wrong");
endmodule
`default_nettype wire

// *** bench/crrsx_core_tb_top.sv ***
// Self-checking bench for the return/rotate/subtract/xor execution slice.
// Assumes the package and crrsx_defines.svh are compiled and on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "crrsx_defines.svh"
module crrsx_core_tb_top
  import crrsx_pkg::*;
;
  logic                   clk, rstn, opValid, destBit, wakeReq;
  crrsx_op_type           opCode;
  logic [7:0]             literal, fileRdata, fileWdata, workingRegister;
  logic [`CRRSX_PC_W-1:0] callTarget, progCounter, tgtNext;
  logic                   fileWe, opReady, carryFlag, halfCarryFlag, zeroFlag;
  logic                   watchdogExpiryFlag, powerdownFlag, sleeping;
  logic [7:0]             watchdogCounter, watchdogPrescaler;
  // Expected state kept by the bench, never read back from the design
  logic [7:0]             expW;
  logic                   expC, expH, expZ;
  int                     n_mismatch, samples_checked, cycles;

  crrsx_core crrsx_core_inst (.clk(clk), .rstn(rstn), .opValid(opValid), .opCode(opCode),
    .destBit(destBit), .literal(literal), .callTarget(callTarget), .fileRdata(fileRdata),
    .wakeReq(wakeReq), .fileWe(fileWe), .fileWdata(fileWdata), .opReady(opReady),
    .workingRegister(workingRegister), .carryFlag(carryFlag), .halfCarryFlag(halfCarryFlag),
    .zeroFlag(zeroFlag), .watchdogExpiryFlag(watchdogExpiryFlag),
    .powerdownFlag(powerdownFlag), .watchdogCounter(watchdogCounter),
    .watchdogPrescaler(watchdogPrescaler), .sleeping(sleeping), .progCounter(progCounter));

  // 25 MHz clock
  always #20 clk = ~clk;

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // One compare task per result width
  task automatic check1(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check10(input logic [9:0] got, input logic [9:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Reset held 12 cycles; the model state follows the documented reset values
  task automatic doReset();
    @(posedge clk);
    rstn <= 1'b0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    expW = 8'h00; expC = 1'b0; expH = 1'b0; expZ = 1'b0;
  endtask

  // One request; returns 1 ns after the taking edge so results have landed
  task automatic runOp(input crrsx_op_type op, input logic d, input logic [7:0] lit,
                       input logic [7:0] fr);
    @(posedge clk);
    opValid    <= 1'b1;
    opCode     <= op;
    destBit    <= d;
    literal    <= lit;
    fileRdata  <= fr;
    callTarget <= tgtNext;
    @(posedge clk);
    opValid <= 1'b0;
    #1;
  endtask

  // Destination steering and working register contents
  task automatic checkRes(input logic d, input logic [7:0] val);
    check1(fileWe, d);
    if (d) check8(fileWdata, val);
    else expW = val;
    check8(workingRegister, expW);
  endtask
  task automatic checkFlags();
    check1(carryFlag, expC);
    check1(halfCarryFlag, expH);
    check1(zeroFlag, expZ);
  endtask

  // Loads W through the literal xor, since W is only reachable by operations
  task automatic setW(input logic [7:0] v);
    runOp(OP_LIT_XOR, 1'b0, expW ^ v, 8'h00);
    expZ = (v == 8'h00);
    checkRes(1'b0, v);
    checkFlags();
  endtask

  task automatic testReset();
    check1(opReady, 1'b1);
    check1(watchdogExpiryFlag, 1'b1);
    check1(powerdownFlag, 1'b1);
    check1(sleeping, 1'b0);
    check10(progCounter, 10'h000);
    checkRes(1'b0, 8'h00);
    checkFlags();
    $display("test reset done");
  endtask

  task automatic testXor();
    setW(8'h3c);
    runOp(OP_REG_XOR, 1'b1, 8'h00, 8'h3c);
    expZ = 1'b1;
    checkRes(1'b1, 8'h00);
    checkFlags();
    runOp(OP_REG_XOR, 1'b0, 8'h00, 8'hff);
    expZ = 1'b0;
    checkRes(1'b0, 8'hc3);
    checkFlags();
    setW(8'h00);
    $display("test xor done");
  endtask

  // Both directions, both destinations, carry chained between steps
  task automatic testRotate();
    logic [7:0] fr;
    for (int i = 0; i < 4; i++) begin
      fr = i[0] ? 8'ha5 : 8'h5a;
      runOp(OP_ROT_LEFT, i[1], 8'h00, fr);
      checkRes(i[1], {fr[6:0], expC});
      expC = fr[7];
      checkFlags();
      runOp(OP_ROT_RIGHT, i[1], 8'h00, fr);
      checkRes(i[1], {expC, fr[7:1]});
      expC = fr[0];
      checkFlags();
    end
    $display("test rotate done");
  endtask

  // Boundaries: equal, nibble borrow, full borrow, no borrow
  task automatic testSub();
    crrsx_op_type ops[3] = '{OP_SUB_BORROW, OP_REG_MINUS_W, OP_LIT_MINUS_W};
    logic [7:0]   fs[4]  = '{8'h35, 8'h10, 8'h00, 8'hff};
    logic [7:0]   ws[4]  = '{8'h35, 8'h01, 8'h01, 8'h00};
    logic [8:0]   s;
    logic [4:0]   h;
    logic         d, cin;
    for (int o = 0; o < 3; o++) begin
      for (int k = 0; k < 4; k++) begin
        setW(ws[k]);
        d   = (ops[o] != OP_LIT_MINUS_W);
        cin = (ops[o] == OP_SUB_BORROW) ? expC : 1'b1;
        s   = {1'b0, fs[k]} + {1'b0, ~ws[k]} + {8'h00, cin};
        h   = {1'b0, fs[k][3:0]} + {1'b0, ~ws[k][3:0]} + {4'h0, cin};
        runOp(ops[o], d, fs[k], fs[k]);
        expC = s[8];
        expH = h[4];
        expZ = (s[7:0] == 8'h00);
        checkRes(d, s[7:0]);
        checkFlags();
      end
    end
    $display("test subtract done");
  endtask

  task automatic testSwap();
    for (int i = 0; i < 2; i++) begin
      runOp(OP_NIBBLE_EXCH, i[0], 8'h00, 8'h1e);
      checkRes(i[0], 8'he1);
      checkFlags();
    end
    $display("test swap done");
  endtask

  // Two-cycle branch: ready drops for one cycle, PC lands at the second edge
  task automatic branch(input crrsx_op_type op, input logic [7:0] lit,
                        input logic [9:0] pc);
    runOp(op, 1'b0, lit, 8'h00);
    check1(opReady, 1'b0);
    @(posedge clk);
    #1;
    check1(opReady, 1'b1);
    check10(progCounter, pc);
    checkFlags();
    check8(workingRegister, expW);
  endtask

  // Mid-run reset first so the program counter starts from a known zero
  task automatic testCallReturn();
    doReset();
    tgtNext = 10'h2a5;
    branch(OP_CALL, 8'h00, 10'h2a5);
    branch(OP_RETURN, 8'h00, 10'h001);
    tgtNext = 10'h3ff;
    branch(OP_CALL, 8'h00, 10'h3ff);
    expW = 8'h9c;
    branch(OP_POP_LIT, 8'h9c, 10'h002);
    $display("test call return done");
  endtask

  task automatic testSleep();
    int n;
    // Past one prescaler wrap, so the counter byte is nonzero before sleep
    repeat (300) @(posedge clk);
    runOp(OP_SLEEP, 1'b0, 8'h00, 8'h00);
    check1(watchdogExpiryFlag, 1'b1);
    check1(powerdownFlag, 1'b0);
    check8(watchdogCounter, 8'h00);
    check8(watchdogPrescaler, 8'h00);
    check1(sleeping, 1'b1);
    // A request while asleep must be dropped
    runOp(OP_LIT_XOR, 1'b0, 8'hff, 8'h00);
    check8(workingRegister, expW);
    @(posedge clk);
    wakeReq <= 1'b1;
    n = 0;
    while (opReady !== 1'b1 && n < 10) begin
      @(posedge clk);
      #1;
      n++;
    end
    check1(opReady, 1'b1);
    check1(sleeping, 1'b0);
    @(posedge clk);
    wakeReq <= 1'b0;
    $display("test sleep done");
  endtask

  initial begin
    clk = 1'b0; rstn = 1'b0; opValid = 1'b0; opCode = OP_NONE; destBit = 1'b0;
    literal = 8'h00; fileRdata = 8'h00; callTarget = 10'h000; tgtNext = 10'h000;
    wakeReq = 1'b0; n_mismatch = 0; samples_checked = 0; cycles = 0;
    doReset();
    #1;
    testReset();
    testXor();
    testRotate();
    testSub();
    testSwap();
    testCallReturn();
    testSleep();
    summarize();
  end
endmodule
`default_nettype wire
